// ---- sim/iscs_far_model.sv ----
/*
 * Behavioural far side of the slow channel shuttle, acting as responder.
 * Assumes the side under test paces the exchange with 7-bit packets lsb first.
 */
`default_nettype none

module iscs_far_model
    import iscs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [SLOW_N-1:0] i_slow,
    input wire logic [FAST_N-1:0] i_fast,
    input wire logic i_mute,
    input wire logic i_drop,
    input wire logic i_rx_bit,
    input wire logic i_rx_valid,
    output logic o_tx_bit,
    output logic o_tx_valid,
    output logic [FAST_N-1:0] o_set_pulse,
    output logic [FAST_N-1:0] o_clr_pulse,
    output logic [PKT_W-1:0] o_got_pkt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PKT_W-1:0] rx_sh;
    logic [PKT_W-1:0] tx_sh;
    logic [FAST_N-1:0] fast_d;
    int rx_cnt;
    int tx_cnt;

    // Lost pulses on demand, so only the slow path can repair the level
    assign o_set_pulse = i_drop ? '0 : i_fast & ~fast_d;
    assign o_clr_pulse = i_drop ? '0 : ~i_fast & fast_d;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_cnt <= 0;
            tx_cnt <= 0;
            rx_sh <= '0;
            tx_sh <= '0;
            fast_d <= '0;
            o_got_pkt <= '0;
            o_tx_valid <= 1'b0;
            o_tx_bit <= 1'b0;
        end else begin
            fast_d <= i_fast;
            if (tx_cnt != 0) begin
                o_tx_bit <= tx_sh[0];
                tx_sh <= tx_sh >> 1;
                tx_cnt <= tx_cnt - 1;
            end else begin
                // Idle bit toggles so a stale value never looks valid
                o_tx_valid <= 1'b0;
                o_tx_bit <= ~o_tx_bit;
            end
            if (i_rx_valid) begin
                rx_sh <= {i_rx_bit, rx_sh[PKT_W-1:1]};
                rx_cnt <= (rx_cnt == PKT_W - 1) ? 0 : rx_cnt + 1;
                if (rx_cnt == PKT_W - 1) begin
                    o_got_pkt <= {i_rx_bit, rx_sh[PKT_W-1:1]};
                    if (!i_mute) begin
                        o_tx_valid <= 1'b1;
                        o_tx_bit <= i_slow[0];
                        tx_sh <= {i_fast, i_slow} >> 1;
                        tx_cnt <= PKT_W - 1;
                    end
                end
            end
        end
    end
endmodule : iscs_far_model

`default_nettype wire

// ---- sim/iscs_tb.sv ----
/*
 * Self-checking bench for one side of the slow channel shuttle.
 * Assumes the design package and the far side model in iscs_far_model.sv.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import iscs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [SLOW_N-1:0] slow_in = '0, p_slow = '0, old_s, slow_out;
    logic [FAST_N-1:0] fast_in = '0, p_fast = '0, old_f, fast_out, setp, clrp, hs_set, hs_clr, dc_fix;
    logic slow_oe, fast_oe, tx_bit, tx_valid, rx_bit, rx_valid, mute = 1'b0, drop = 1'b0;
    logic [PKT_W-1:0] got;
    logic [31:0] seed = 32'h14, r;
    logic [SLOW_N-1:0] rsp_slow;
    logic [FAST_N-1:0] rsp_fast;
    logic rsp_soe, rsp_foe;
    int mismatches = 0, checked = 0, fixes = 0, splits = 0, n, t1, t2;

    iscs_side i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_initiator(1'b1), .i_slow_in(slow_in),
        .o_slow_out(slow_out), .o_slow_oe(slow_oe), .i_fast_in(fast_in), .o_fast_out(fast_out),
        .o_fast_oe(fast_oe), .o_hs_set_pulse(setp), .o_hs_clr_pulse(clrp), .i_hs_set_pulse(hs_set),
        .i_hs_clr_pulse(hs_clr), .o_link_tx_bit(tx_bit), .o_link_tx_valid(tx_valid),
        .i_link_rx_bit(rx_bit), .i_link_rx_valid(rx_valid), .o_dc_fix(dc_fix));
    iscs_far_model i_far (.i_clk(clk), .i_reset_n(rst_n), .i_slow(p_slow), .i_fast(p_fast),
        .i_mute(mute), .i_drop(drop), .i_rx_bit(tx_bit), .i_rx_valid(tx_valid), .o_tx_bit(rx_bit),
        .o_tx_valid(rx_valid), .o_set_pulse(hs_set), .o_clr_pulse(hs_clr), .o_got_pkt(got));
    // Responder copy listens to the initiator so the reply path is exercised too
    iscs_side i_dut_rsp (.i_clk(clk), .i_reset_n(rst_n), .i_initiator(1'b0), .i_slow_in(p_slow),
        .o_slow_out(rsp_slow), .o_slow_oe(rsp_soe), .i_fast_in(p_fast), .o_fast_out(rsp_fast),
        .o_fast_oe(rsp_foe), .o_hs_set_pulse(), .o_hs_clr_pulse(), .i_hs_set_pulse(setp),
        .i_hs_clr_pulse(clrp), .o_link_tx_bit(), .o_link_tx_valid(),
        .i_link_rx_bit(tx_bit), .i_link_rx_valid(tx_valid), .o_dc_fix());

    always #50 clk = ~clk;
    always @(posedge clk) if ((|dc_fix) === 1'b1) fixes++;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [FAST_N-1:0] rise(input logic [FAST_N-1:0] a, input logic [FAST_N-1:0] b);
        return a & ~b;
    endfunction : rise

    task automatic fail(input string msg);
        mismatches++;
        $display("unexpected %0t %s", $time, msg);
    endtask : fail

    task automatic chk(input logic [7:0] v, input logic [7:0] e, input string msg);
        checked++;
        if (v !== e) fail(msg);
    endtask : chk

    task automatic chk_in(input int v, input int lo, input int hi, input string msg);
        checked++;
        if (v < lo || v > hi) fail(msg);
    endtask : chk_in

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({slow_oe, fast_oe}, 0, "driven before packet");
        repeat (40) @(posedge clk);
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            r = rnd();
            old_s = p_slow;
            old_f = fast_in;
            slow_in <= r[2:0];
            fast_in <= r[6:3];
            p_slow <= r[9:7];
            p_fast <= r[13:10];
            #1 chk(setp, rise(r[6:3], old_f), "set pulse");
            chk(clrp, rise(old_f, r[6:3]), "clear pulse");
            n = 0;
            while (slow_out !== r[9:7] && n < 40) begin
                if (slow_out !== old_s) fail("split output update");
                @(posedge clk);
                #1 n++;
            end
            if (r[9:7] !== old_s) chk_in(n, 1, DELAY_MAX_NS / CLK_NS, "slow delay");
            repeat (34) @(posedge clk);
            #1 chk(got, {r[6:3], r[2:0]}, "sampled packet");
            chk(fast_out, r[13:10], "fast level");
            chk({slow_oe, fast_oe}, 3, "output enable");
            chk({rsp_fast, rsp_slow}, r[6:0], "responder packet");
            chk({rsp_soe, rsp_foe}, 3, "responder enable");
        end
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            p_slow <= '0;
            // Pass length is one cycle over a slot multiple, so every sample phase is hit once
            repeat (55) @(posedge clk);
            p_slow <= 3'b010;
            @(posedge clk);
            p_slow <= 3'b110;
            t1 = -1;
            t2 = -1;
            for (int c = 0; c < 40; c++) begin
                @(posedge clk);
                #1 if (slow_out[1] === 1'b1 && t1 < 0) t1 = c;
                if (slow_out[2] === 1'b1 && t2 < 0) t2 = c;
            end
            chk(t1 >= 0 && (t2 == t1 || t2 - t1 == SLOT_CYC), 1, "edge gap or order");
            if (t2 - t1 == SLOT_CYC) splits++;
        end
        chk(8'(splits), 1, "split edge phase count");
        @(posedge clk);
        mute <= 1'b1;
        #1 n = 0;
        while (slow_oe === 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        // Last reply lands up to a packet after the mute, or up to a slot gap before it
        chk_in(n, WDOG_CYC + 1 - (SLOT_CYC - PKT_W - 1), WDOG_CYC + 1 + PKT_W, "watchdog time");
        chk(fast_oe, 0, "fast enable");
        @(posedge clk);
        mute <= 1'b0;
        repeat (40) @(posedge clk);
        #1 chk({slow_oe, slow_out}, {1'b1, p_slow}, "recovery");
        @(posedge clk);
        drop <= 1'b1;
        p_fast <= ~p_fast;
        n = fixes;
        repeat (40) @(posedge clk);
        #1 chk(fast_out, p_fast, "refresh level");
        chk_in(fixes - n, 1, 2, "refresh pulses");
        drop <= 1'b0;
        stop_test();
    end
endmodule : testbench

`default_nettype wire

// ---- src/iscs_hs_path.sv ----
/*
 * Package for the slow channel shuttle, plus the fast channel edge path:
 * transition pulses out, bistable level decoders in, and correction of those
 * decoders from the slow packet.
 * Assumes a single free running clock and synchronous inputs.
 */
`default_nettype none

package iscs_pkg;
    localparam int CLK_NS = 100;
    localparam int SLOW_N = 3;
    localparam int FAST_N = 4;
    localparam int PKT_W = SLOW_N + FAST_N;
    localparam int SLOW_LSB = 0;
    localparam int FAST_LSB = SLOW_N;
    // Sample slot of the free running pacing clock
    localparam int SLOT_NS = 1600;
    localparam int SLOT_CYC = (SLOT_NS + CLK_NS - 1) / CLK_NS;
    // Input to output delay window of a slow channel
    localparam int DELAY_MIN_NS = 100;
    localparam int DELAY_MAX_NS = 2600;
    // Fast channel quiet time before refresh correction applies
    localparam int REFRESH_NS = 1200;
    localparam int REFRESH_CYC = (REFRESH_NS + CLK_NS - 1) / CLK_NS;
    // Link silence before the far side is taken as unpowered
    localparam int WDOG_NS = 5000;
    localparam int WDOG_CYC = (WDOG_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = 5;
    localparam int BIT_W = 3;
    localparam int WD_W = 6;
    localparam int IDLE_W = 4;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SLOT_CYC - 1);
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(PKT_W - 1);
    localparam logic [WD_W-1:0] WDOG_LAST = WD_W'(WDOG_CYC);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(REFRESH_CYC);
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_TX = 2'b01,
        ST_RX = 2'b10
    } iscs_state_t;
endpackage : iscs_pkg

module iscs_hs_path
    import iscs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [FAST_N-1:0] i_fast_in,
    output logic [FAST_N-1:0] o_set_pulse,
    output logic [FAST_N-1:0] o_clr_pulse,
    input wire logic [FAST_N-1:0] i_set_pulse,
    input wire logic [FAST_N-1:0] i_clr_pulse,
    input wire logic i_fix_valid,
    input wire logic [FAST_N-1:0] i_fix_level,
    output logic [FAST_N-1:0] o_level,
    output logic [FAST_N-1:0] o_fixed
);
    logic [FAST_N-1:0] in_prev_reg;
    logic [FAST_N-1:0] level_reg;
    logic [FAST_N-1:0] level_next;
    logic [FAST_N-1:0] fixed_reg;
    logic [FAST_N-1:0] fixed_next;
    logic [IDLE_W-1:0] idle_reg [FAST_N];
    logic [IDLE_W-1:0] idle_next [FAST_N];

    // One clock pulse per input transition
    assign o_set_pulse = i_fast_in & ~in_prev_reg;
    assign o_clr_pulse = ~i_fast_in & in_prev_reg;
    assign o_level = level_reg;
    assign o_fixed = fixed_reg;

    always_comb begin
        level_next = level_reg;
        fixed_next = '0;
        for (int i = 0; i < FAST_N; i++) begin
            idle_next[i] = idle_reg[i];
            if (i_set_pulse[i] || i_clr_pulse[i]) begin
                idle_next[i] = '0;
            end else if (idle_reg[i] != IDLE_LAST) begin
                idle_next[i] = idle_reg[i] + IDLE_W'(1);
            end
            if (i_set_pulse[i]) begin
                level_next[i] = 1'b1;
            end else if (i_clr_pulse[i]) begin
                level_next[i] = 1'b0;
            end else if (i_fix_valid && idle_reg[i] == IDLE_LAST && level_reg[i] != i_fix_level[i]) begin
                // Only a quiet channel is corrected, so an edge in flight never loses to a stale sample
                level_next[i] = i_fix_level[i];
                fixed_next[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_prev_reg <= '0;
            level_reg <= '0;
            fixed_reg <= '0;
            for (int i = 0; i < FAST_N; i++) begin
                idle_reg[i] <= '0;
            end
        end else begin
            in_prev_reg <= i_fast_in;
            level_reg <= level_next;
            fixed_reg <= fixed_next;
            for (int i = 0; i < FAST_N; i++) begin
                idle_reg[i] <= idle_next[i];
            end
        end
    end
endmodule : iscs_hs_path

`default_nettype wire

// ---- src/iscs_side.sv ----
/*
 * One isolated side of the slow channel shuttle: samples local inputs into a
 * packet, exchanges packets ping-pong with the far side, drives the slow
 * outputs, corrects fast channel levels and runs the silence watchdog.
 * Assumes the far side is an identical block with the opposite i_initiator.
 */
`default_nettype none

// Contract
// - Sample every fast and slow input at one instant and pack them.
// - Check received fast levels against decoders; route slow bits to outputs.
// - After one direction, sample the other side and send back; alternate forever.
// - Update all slow outputs from one packet on the same clock.
// - Pace sampling and exchange from a free running internal clock.
// - Slow channel delay lies between 0.1 and 2.6 microseconds.
// - Close edges split by a sample come out one period apart.
// - Edges within one sample interval leave on the same instant.
// - Edges separated by the minimum skew never swap order.
// - A fast input transition makes a short pulse setting a bistable decoder.
// - Quiet fast inputs get periodic level refresh over the slow path.
// - No pulses for about 5 microseconds forces local outputs to high impedance.
module iscs_side
    import iscs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_initiator,
    input wire logic [SLOW_N-1:0] i_slow_in,
    output logic [SLOW_N-1:0] o_slow_out,
    output logic o_slow_oe,
    input wire logic [FAST_N-1:0] i_fast_in,
    output logic [FAST_N-1:0] o_fast_out,
    output logic o_fast_oe,
    output logic [FAST_N-1:0] o_hs_set_pulse,
    output logic [FAST_N-1:0] o_hs_clr_pulse,
    input wire logic [FAST_N-1:0] i_hs_set_pulse,
    input wire logic [FAST_N-1:0] i_hs_clr_pulse,
    output logic o_link_tx_bit,
    output logic o_link_tx_valid,
    input wire logic i_link_rx_bit,
    input wire logic i_link_rx_valid,
    output logic [FAST_N-1:0] o_dc_fix
);
    iscs_state_t state_reg;
    iscs_state_t state_next;
    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic tick;
    logic [BIT_W-1:0] bit_cnt_reg;
    logic [BIT_W-1:0] bit_cnt_next;
    logic [PKT_W-1:0] tx_shift_reg;
    logic [PKT_W-1:0] tx_shift_next;
    logic [PKT_W-1:0] rx_shift_reg;
    logic [PKT_W-1:0] rx_shift_next;
    logic [PKT_W-1:0] sample;
    logic [SLOW_N-1:0] slow_out_reg;
    logic [SLOW_N-1:0] slow_out_next;
    logic [WD_W-1:0] wd_cnt_reg;
    logic [WD_W-1:0] wd_cnt_next;
    logic wd_expired;
    logic alive_reg;
    logic alive_next;
    logic rx_done;
    logic [FAST_N-1:0] fast_level;

    // Free running pacing clock, never reset by link activity
    assign tick = (tick_reg == TICK_LAST);
    // One slot of pacing bounds the slow channel delay window
    assign tick_next = tick ? '0 : tick_reg + TICK_W'(1);

    // All inputs caught in one flop load; edges in one slot leave together
    assign sample = {i_fast_in, i_slow_in};
    assign wd_expired = (wd_cnt_reg == WDOG_LAST);

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        tx_shift_next = tx_shift_reg;
        rx_shift_next = rx_shift_reg;
        slow_out_next = slow_out_reg;
        rx_done = 1'b0;
        case (state_reg)
            ST_WAIT: begin
                if (!i_initiator) begin
                    state_next = ST_RX;
                end else if (tick) begin
                    tx_shift_next = sample;
                    bit_cnt_next = '0;
                    state_next = ST_TX;
                end
            end
            ST_TX: begin
                tx_shift_next = tx_shift_reg >> 1;
                if (bit_cnt_reg == BIT_LAST) begin
                    bit_cnt_next = '0;
                    state_next = ST_RX;
                end else begin
                    bit_cnt_next = bit_cnt_reg + BIT_W'(1);
                end
            end
            ST_RX: begin
                if (i_link_rx_valid) begin
                    rx_shift_next = {i_link_rx_bit, rx_shift_reg[PKT_W-1:1]};
                    if (bit_cnt_reg == BIT_LAST) begin
                        rx_done = 1'b1;
                        bit_cnt_next = '0;
                        // Whole packet lands at once: order kept, close edges pushed a slot apart
                        slow_out_next = rx_shift_next[SLOW_LSB +: SLOW_N];
                        if (i_initiator) begin
                            state_next = ST_WAIT;
                        end else begin
                            tx_shift_next = sample;
                            state_next = ST_TX;
                        end
                    end else begin
                        bit_cnt_next = bit_cnt_reg + BIT_W'(1);
                    end
                end else if (wd_expired) begin
                    // A dead partner must not hang the initiator's schedule
                    bit_cnt_next = '0;
                    if (i_initiator) begin
                        state_next = ST_WAIT;
                    end
                end
            end
            default: begin
                state_next = ST_WAIT;
                bit_cnt_next = '0;
            end
        endcase
    end

    always_comb begin
        wd_cnt_next = wd_cnt_reg;
        if (i_link_rx_valid) begin
            wd_cnt_next = '0;
        end else if (!wd_expired) begin
            wd_cnt_next = wd_cnt_reg + WD_W'(1);
        end
        alive_next = alive_reg;
        if (rx_done) begin
            alive_next = 1'b1;
        end else if (wd_expired) begin
            alive_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_WAIT;
            tick_reg <= '0;
            bit_cnt_reg <= '0;
            tx_shift_reg <= '0;
            rx_shift_reg <= '0;
            slow_out_reg <= '0;
            wd_cnt_reg <= '0;
            alive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            bit_cnt_reg <= bit_cnt_next;
            tx_shift_reg <= tx_shift_next;
            rx_shift_reg <= rx_shift_next;
            slow_out_reg <= slow_out_next;
            wd_cnt_reg <= wd_cnt_next;
            alive_reg <= alive_next;
        end
    end

    iscs_hs_path u_hs_path (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_fast_in(i_fast_in),
        .o_set_pulse(o_hs_set_pulse),
        .o_clr_pulse(o_hs_clr_pulse),
        .i_set_pulse(i_hs_set_pulse),
        .i_clr_pulse(i_hs_clr_pulse),
        .i_fix_valid(rx_done),
        .i_fix_level(rx_shift_next[FAST_LSB +: FAST_N]),
        .o_level(fast_level),
        .o_fixed(o_dc_fix)
    );

    assign o_link_tx_bit = tx_shift_reg[0];
    assign o_link_tx_valid = (state_reg == ST_TX);
    assign o_slow_out = slow_out_reg;
    assign o_fast_out = fast_level;
    // Outputs float until the first packet proves the far side is powered
    assign o_slow_oe = alive_reg;
    assign o_fast_oe = alive_reg;

    a_tick_period: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        tick |=> (!tick) [*8] ##7 (!tick) ##1 tick)
        else $error("pacing tick period wrong");

    a_tx_sample: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_reg == ST_WAIT && i_initiator && tick) |=> tx_shift_reg == $past(sample))
        else $error("packet does not hold the sampled inputs");

    a_tx_burst: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_link_tx_valid) |-> o_link_tx_valid [*7] ##1 !o_link_tx_valid)
        else $error("packet length is not seven bits");

    a_out_update: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        rx_done |=> o_slow_out == $past(rx_shift_next[SLOW_LSB +: SLOW_N]))
        else $error("slow outputs not updated from packet");

    a_out_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !rx_done |=> $stable(o_slow_out))
        else $error("slow outputs changed without a packet");

    a_ping_pong: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (rx_done && !i_initiator) |=> state_reg == ST_TX ##7 state_reg == ST_RX)
        else $error("responder did not answer");

    a_tx_paced: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_reg == ST_TX && $past(state_reg) == ST_WAIT) |-> $past(tick))
        else $error("initiator sent off the pacing tick");

    a_wd_hiz: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wd_cnt_reg == WDOG_LAST && !i_link_rx_valid) |=> !o_slow_oe && !o_fast_oe)
        else $error("watchdog did not float outputs");
endmodule : iscs_side

`default_nettype wire
